// ---- hms_defines.svh ----
// Purpose: Register offsets, field positions, reset values and counts for the mode-select block
// Assumes: Included by bare name from the CORDIC and mode-select design files
// Notes: Definitions only
`ifndef HMS_DEFINES_SVH
`define HMS_DEFINES_SVH

// Register offsets (word addresses on the register port)
`define HMS_ADDR_SETTINGS 16'h000b
`define HMS_ADDR_COMP_A 16'h0111
`define HMS_ADDR_COMP_B 16'h0112
`define HMS_ADDR_COMP_C 16'h0113
`define HMS_ADDR_COMP_D 16'h0114
`define HMS_ADDR_MAG 16'h0120
`define HMS_ADDR_ANG 16'h0121
`define HMS_ADDR_LIN_ANG 16'h0122

// Settings register layout and reset
`define HMS_SETTINGS_RESET 16'h0002
`define HMS_SETTINGS_WMASK 16'h08d2
`define HMS_BIT_RANGE_EXT 11
`define HMS_BIT_RDY_TRI 1
`define HMS_MODE_MSB 7
`define HMS_MODE_LSB 4

// Mode field codes, bits 7..4
`define HMS_CODE_TOP_GRAD 4'h9
`define HMS_CODE_SIDE_ABS 4'hc
`define HMS_CODE_SIDE_GRAD 4'hd

// Counts
`define HMS_RST_CYCLES 16
`define HMS_CORDIC_ITER 16
`define HMS_ANGLE_HALF 16'h8000
`define HMS_RESULT_RESET 16'h0000

`endif

// ---- hms_pkg.sv ----
// Purpose: Types shared by the mode-select block
// Assumes: Nothing beyond the defines header
// Notes: Types only; numbers live in the defines header
`default_nettype none
package hms_pkg;
  typedef enum logic [1:0] {
    MODE_TOP_GRAD,
    MODE_SIDE_ABS,
    MODE_SIDE_GRAD,
    MODE_NONE
  } hms_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CALC
  } hms_state_e;
endpackage
`default_nettype wire

// ---- hms_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter for a pin level
// Assumes: Pin is asynchronous to clk
// Notes: Level only changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module hms_sync (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic pinIn, // Asynchronous pin level
  output logic levelOut // Filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // First stage feeds only the second, to contain metastability
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign levelOut = level_q;
endmodule
`default_nettype wire

// ---- hms_cordic.sv ----
// Purpose: Iterative vectoring CORDIC giving half-gain magnitude and atan2 angle
// Assumes: Inputs stable in the start cycle; one result per start
// Notes: Half of the CORDIC gain lands on the 0.8234 magnitude scale
`timescale 1ns/1ns
`default_nettype none
`include "hms_defines.svh"
module hms_cordic #(
  parameter int W = 17,
  parameter int ITER = `HMS_CORDIC_ITER
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous clear, also aborts a run
  input wire logic start, // One-cycle start pulse
  input wire logic signed [W-1:0] xIn, // Horizontal operand
  input wire logic signed [W-1:0] yIn, // Vertical operand
  output logic busy, // Iterations running
  output logic done, // One-cycle result pulse
  output logic [15:0] magOut, // Scaled magnitude, saturated
  output logic [15:0] angOut // Angle, full turn is 2^16
);
  // Guard bits below the point; without them shift truncation skews small vectors
  localparam int FB = 8;
  localparam int XW = W + 2 + FB;

  logic signed [XW-1:0] x_q;
  logic signed [XW-1:0] y_q;
  logic [15:0] z_q;
  logic [4:0] it_q;
  logic running_q;
  logic done_q;
  logic [15:0] mag_q;
  logic [15:0] ang_q;

  // Arctangent of 2^-i in units of a 2^16 full turn
  function automatic logic [15:0] atanStep(input logic [4:0] i);
    case (i)
      5'h00: atanStep = 16'h2000;
      5'h01: atanStep = 16'h12e4;
      5'h02: atanStep = 16'h09fb;
      5'h03: atanStep = 16'h0511;
      5'h04: atanStep = 16'h028b;
      5'h05: atanStep = 16'h0146;
      5'h06: atanStep = 16'h00a3;
      5'h07: atanStep = 16'h0051;
      5'h08: atanStep = 16'h0029;
      5'h09: atanStep = 16'h0014;
      5'h0a: atanStep = 16'h000a;
      5'h0b: atanStep = 16'h0005;
      5'h0c: atanStep = 16'h0003;
      5'h0d: atanStep = 16'h0001;
      5'h0e: atanStep = 16'h0001;
      default: atanStep = 16'h0000;
    endcase
  endfunction

  // Pre-rotation into the right half plane keeps the loop convergent
  logic signed [XW-1:0] xExt;
  logic signed [XW-1:0] yExt;
  logic inLeft;
  assign xExt = {{2{xIn[W-1]}}, xIn, {FB{1'b0}}};
  assign yExt = {{2{yIn[W-1]}}, yIn, {FB{1'b0}}};
  assign inLeft = xIn[W-1];

  // One micro-rotation step
  logic signed [XW-1:0] xSh;
  logic signed [XW-1:0] ySh;
  logic signed [XW-1:0] xN;
  logic signed [XW-1:0] yN;
  logic [15:0] zN;
  logic lastIt;
  assign xSh = x_q >>> it_q;
  assign ySh = y_q >>> it_q;
  assign xN = y_q[XW-1] ? x_q - ySh : x_q + ySh;
  assign yN = y_q[XW-1] ? y_q + xSh : y_q - xSh;
  assign zN = y_q[XW-1] ? z_q - atanStep(it_q) : z_q + atanStep(it_q);
  assign lastIt = (it_q == 5'(ITER - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      x_q <= '0;
      y_q <= '0;
      z_q <= 16'h0000;
      it_q <= 5'h00;
      running_q <= 1'b0;
      done_q <= 1'b0;
      mag_q <= 16'h0000;
      ang_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (start && !running_q) begin
        x_q <= inLeft ? -xExt : xExt;
        y_q <= inLeft ? -yExt : yExt;
        z_q <= inLeft ? `HMS_ANGLE_HALF : 16'h0000;
        it_q <= 5'h00;
        running_q <= 1'b1;
      end else if (running_q) begin
        x_q <= xN;
        y_q <= yN;
        z_q <= zN;
        it_q <= it_q + 5'h01;
        if (lastIt) begin
          running_q <= 1'b0;
          done_q <= 1'b1;
          mag_q <= (|xN[XW-1:FB+17]) ? 16'hffff : xN[FB+16:FB+1]; // Halved gain, saturated
          ang_q <= zN;
        end
      end
    end
  end

  assign busy = running_q;
  assign done = done_q;
  assign magOut = mag_q;
  assign angOut = ang_q;
endmodule
`default_nettype wire

// ---- hms_mode_select.sv ----
// Purpose: Settings register, component mapping, magnitude/angle results, low-power control
// Assumes: Front end delivers six pixel components with a strobe; register port is word based
// Notes: Low-power entry halts measurement, result storing and the register port; leaving it runs an internal reset cycle
`timescale 1ns/1ns
`default_nettype none
`include "hms_defines.svh"

module hms_mode_select
  import hms_pkg::*;
#(
  parameter int RST_CYCLES = `HMS_RST_CYCLES,
  parameter int ITER = `HMS_CORDIC_ITER
) (
  input wire logic clk, // Core clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic lowPowerPin, // Low-power request pin, asynchronous
  input wire logic regWrEn, // Register write strobe
  input wire logic regRdEn, // Register read strobe
  input wire logic [15:0] regAddr, // Register word address
  input wire logic [15:0] regWrData, // Register write data
  output logic [15:0] regRdData, // Register read data
  output logic regRdValid, // Read data valid pulse
  input wire logic measTrigger, // Start of a measurement cycle
  input wire logic sampleValid, // Pixel components valid
  input wire logic signed [15:0] pixBx0, // Pixel 0 x component
  input wire logic signed [15:0] pixBy0, // Pixel 0 y component
  input wire logic signed [15:0] pixBz0, // Pixel 0 z component
  input wire logic signed [15:0] pixBx1, // Pixel 1 x component
  input wire logic signed [15:0] pixBy1, // Pixel 1 y component
  input wire logic signed [15:0] pixBz1, // Pixel 1 z component
  output logic analogEnable, // Analog front end power
  output logic measBusy, // Measurement cycle in progress
  output logic resultValid, // New results pulse
  output logic readyPinTristate, // Settings bit 1
  output logic magnetRangeExtension, // Settings bit 11
  output logic resetCycleBusy // Reset cycle after low power
);
  localparam int CW = $clog2(RST_CYCLES + 1);

  // Low-power pin level and its falling edge
  logic lpLevel;
  logic lpPrev_q;
  logic lpFall;

  hms_sync u_hms_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(lowPowerPin),
    .levelOut(lpLevel)
  );

  assign lpFall = ~lpLevel & lpPrev_q;

  // Reset cycle counter; rst held high also clears it on a clock edge
  // Reloaded on every fall, so a second short pulse restarts the full cycle
  logic [CW-1:0] rstCnt_q;
  logic [CW-1:0] rstCnt_d;
  logic resetActive;
  logic halt;
  logic regClear;
  assign resetActive = (rstCnt_q != '0);
  assign rstCnt_d = lpFall ? CW'(RST_CYCLES) : (resetActive ? rstCnt_q - 1'b1 : rstCnt_q);
  assign halt = lpLevel | resetActive;
  assign regClear = rst | lpFall | resetActive;

  always_ff @(posedge clk) begin
    if (rst) begin
      lpPrev_q <= 1'b0;
      rstCnt_q <= '0;
    end else begin
      lpPrev_q <= lpLevel;
      rstCnt_q <= rstCnt_d;
    end
  end

  // Settings register; unwritable bits read back as zero
  // Writes while halted are dropped, not queued; the host must rewrite them
  logic [15:0] settings_q;
  logic [15:0] settings_d;
  logic portOpen;
  logic settingsWr;
  assign portOpen = ~halt;
  assign settingsWr = portOpen & regWrEn & (regAddr == `HMS_ADDR_SETTINGS);
  assign settings_d = settingsWr ? (regWrData & `HMS_SETTINGS_WMASK) : settings_q;

  always_ff @(posedge clk) begin
    if (regClear) begin
      settings_q <= `HMS_SETTINGS_RESET;
    end else begin
      settings_q <= settings_d;
    end
  end

  assign readyPinTristate = settings_q[`HMS_BIT_RDY_TRI];
  assign magnetRangeExtension = settings_q[`HMS_BIT_RANGE_EXT];

  // Mode decode from bits 7..4; range extension and ready bits do not alter the mode
  logic [3:0] modeCode;
  hms_mode_e modeNow;
  assign modeCode = settings_q[`HMS_MODE_MSB:`HMS_MODE_LSB];
  assign modeNow = (modeCode == `HMS_CODE_TOP_GRAD) ? MODE_TOP_GRAD :
                   (modeCode == `HMS_CODE_SIDE_ABS) ? MODE_SIDE_ABS :
                   (modeCode == `HMS_CODE_SIDE_GRAD) ? MODE_SIDE_GRAD :
                   MODE_NONE;

  // Measurement sequencer; mode is sampled at the trigger only
  // Undefined mode codes never start a cycle, so acquire cannot hang on them
  hms_state_e state_q;
  hms_state_e state_d;
  hms_mode_e measMode_q;
  logic cordDone;
  logic cordBusy;
  logic takeTrigger;
  logic takeSample;
  assign takeTrigger = (state_q == ST_IDLE) & measTrigger & (modeNow != MODE_NONE);
  assign takeSample = (state_q == ST_ACQ) & sampleValid;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (takeTrigger) begin
          state_d = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (sampleValid) begin
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        if (cordDone) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (halt) begin
      state_d = ST_IDLE;
    end
  end

  // Sequencer state; a halted cycle simply ends with no result
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      measMode_q <= MODE_NONE;
    end else begin
      state_q <= state_d;
      if (takeTrigger && !halt) begin
        measMode_q <= modeNow;
      end
    end
  end

  // Component routing per latched mode
  // Differences carry one extra bit so opposite full-scale readings cannot wrap
  logic [15:0] mapA;
  logic [15:0] mapB;
  logic signed [16:0] mapX;
  logic signed [16:0] mapY;
  logic signed [16:0] diffX;
  logic signed [16:0] diffY;
  logic signed [16:0] diffZ;
  logic topMode;
  logic gradMode;
  assign diffX = 17'(pixBx1) - 17'(pixBx0);
  assign diffY = 17'(pixBy1) - 17'(pixBy0);
  assign diffZ = 17'(pixBz1) - 17'(pixBz0);
  assign topMode = (measMode_q == MODE_TOP_GRAD);
  assign gradMode = (measMode_q != MODE_SIDE_ABS);
  assign mapA = topMode ? pixBz0 : pixBy0;
  assign mapB = topMode ? pixBz1 : pixBy1;
  assign mapX = gradMode ? diffX : {pixBx0[15], pixBx0};
  assign mapY = topMode ? diffZ : (gradMode ? diffY : {pixBy0[15], pixBy0});

  // Operand stage into the CORDIC
  // Registered operands cut the path from the pixel inputs into the engine
  logic signed [16:0] cordX_q;
  logic signed [16:0] cordY_q;
  logic cordStart_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cordX_q <= '0;
      cordY_q <= '0;
      cordStart_q <= 1'b0;
    end else begin
      cordStart_q <= takeSample & ~halt;
      if (takeSample) begin
        cordX_q <= mapX;
        cordY_q <= mapY;
      end
    end
  end

  // Engine is held cleared through low power and the reset cycle
  logic [15:0] cordMag;
  logic [15:0] cordAng;
  hms_cordic #(
    .W(17),
    .ITER(ITER)
  ) u_hms_cordic (
    .clk(clk),
    .rst(rst | halt),
    .start(cordStart_q),
    .xIn(cordX_q),
    .yIn(cordY_q),
    .busy(cordBusy),
    .done(cordDone),
    .magOut(cordMag),
    .angOut(cordAng)
  );

  // Output registers; components on the sample, results on completion
  // Components refused in the first halted cycle, before the state falls idle
  // Linearized word copies the raw angle until a correction table is added
  logic [15:0] compA_q;
  logic [15:0] compB_q;
  logic [15:0] compC_q;
  logic [15:0] compD_q;
  logic [15:0] mag_q;
  logic [15:0] ang_q;
  logic [15:0] linAng_q;
  logic resValid_q;
  logic storeRes;
  assign storeRes = cordDone & (state_q == ST_CALC) & ~halt;

  always_ff @(posedge clk) begin
    if (regClear) begin
      compA_q <= `HMS_RESULT_RESET;
      compB_q <= `HMS_RESULT_RESET;
      compC_q <= `HMS_RESULT_RESET;
      compD_q <= `HMS_RESULT_RESET;
      mag_q <= `HMS_RESULT_RESET;
      ang_q <= `HMS_RESULT_RESET;
      linAng_q <= `HMS_RESULT_RESET;
      resValid_q <= 1'b0;
    end else begin
      resValid_q <= storeRes;
      if (takeSample && !lpLevel) begin
        compA_q <= mapA;
        compB_q <= mapB;
        compC_q <= pixBx0;
        compD_q <= pixBx1;
      end
      if (storeRes) begin
        mag_q <= cordMag;
        ang_q <= cordAng;
        linAng_q <= cordAng; // Table correction lives outside this block
      end
    end
  end

  // Read decode; unmapped words read as zero
  logic [15:0] rdMux;
  assign rdMux = (regAddr == `HMS_ADDR_SETTINGS) ? settings_q :
                 (regAddr == `HMS_ADDR_COMP_A) ? compA_q :
                 (regAddr == `HMS_ADDR_COMP_B) ? compB_q :
                 (regAddr == `HMS_ADDR_COMP_C) ? compC_q :
                 (regAddr == `HMS_ADDR_COMP_D) ? compD_q :
                 (regAddr == `HMS_ADDR_MAG) ? mag_q :
                 (regAddr == `HMS_ADDR_ANG) ? ang_q :
                 (regAddr == `HMS_ADDR_LIN_ANG) ? linAng_q :
                 16'h0000;

  // Registered read answer; silent while halted
  // Zero data when refused, so a stale word never leaks onto the port
  logic [15:0] rdData_q;
  logic rdValid_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regRdEn & portOpen;
      rdData_q <= (regRdEn && portOpen) ? rdMux : 16'h0000;
    end
  end

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign analogEnable = ~lpLevel;
  assign measBusy = (state_q != ST_IDLE) | cordBusy;
  assign resultValid = resValid_q;
  assign resetCycleBusy = resetActive;
endmodule
`default_nettype wire

// ---- hms_mode_select_props.sv ----
// Purpose: Port-level checks for the mode-select block
// Assumes: Sees only top ports; analogEnable is the inverse of the synced low-power level
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module hms_mode_select_props #(
  parameter int RST_CYCLES = 16,
  parameter int ITER = 16
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic lowPowerPin, // Low-power pin
  input wire logic regRdEn, // Read strobe
  input wire logic [15:0] regRdData, // Read data
  input wire logic regRdValid, // Read answer
  input wire logic sampleValid, // Components valid
  input wire logic measBusy, // Measuring
  input wire logic resultValid, // Results pulse
  input wire logic analogEnable, // Analog power
  input wire logic readyPinTristate, // Settings bit 1
  input wire logic magnetRangeExtension, // Settings bit 11
  input wire logic resetCycleBusy // Reset cycle
);
  localparam int RES_LAT = ITER + 3;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Length of the running reset cycle, checked when it ends
  logic [7:0] busyLen_q;
  always_ff @(posedge clk) begin
    if (rst || !resetCycleBusy) busyLen_q <= 8'h00;
    else busyLen_q <= busyLen_q + 8'h01;
  end

  a_lp_analog_off: assert property (lowPowerPin [*6] |-> !analogEnable)
    else $error("analog still on in low power");
  a_lp_analog_on: assert property ((!lowPowerPin) [*6] |-> analogEnable)
    else $error("analog off with pin low");
  a_lp_abort: assert property (!analogEnable |=> !measBusy && !resultValid)
    else $error("measurement survives low power");
  a_read_refused: assert property (regRdEn && (!analogEnable || resetCycleBusy)
    |=> !regRdValid && regRdData == 16'h0000)
    else $error("read answered while refused");
  a_read_answer: assert property (regRdEn && analogEnable && !resetCycleBusy |=> regRdValid)
    else $error("read not answered");
  a_data_idle: assert property (!regRdValid |-> regRdData == 16'h0000)
    else $error("read data without valid");
  a_valid_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("read valid without strobe");
  a_reset_len: assert property ($fell(resetCycleBusy) |-> busyLen_q == 8'(RST_CYCLES))
    else $error("reset cycle length wrong");
  a_reset_settings: assert property ($fell(resetCycleBusy)
    |-> readyPinTristate && !magnetRangeExtension)
    else $error("settings not back to initial");
  a_result_lat: assert property (sampleValid && measBusy && !lowPowerPin
    |-> ##RES_LAT (resultValid || !analogEnable))
    else $error("result latency wrong");
  a_result_done: assert property (resultValid |-> !measBusy)
    else $error("busy with result");
endmodule

bind hms_mode_select hms_mode_select_props #(.RST_CYCLES(RST_CYCLES), .ITER(ITER))
  u_hms_mode_select_props (
  .clk(clk),
  .rst(rst),
  .lowPowerPin(lowPowerPin),
  .regRdEn(regRdEn),
  .regRdData(regRdData),
  .regRdValid(regRdValid),
  .sampleValid(sampleValid),
  .measBusy(measBusy),
  .resultValid(resultValid),
  .analogEnable(analogEnable),
  .readyPinTristate(readyPinTristate),
  .magnetRangeExtension(magnetRangeExtension),
  .resetCycleBusy(resetCycleBusy)
);
`default_nettype wire

// ---- hms_host_model.sv ----
// Purpose: Register-port host standing in for the serial controller
// Assumes: Strobes change at the falling edge, one cycle each
// Notes: Idle address and data show inverted values, never the last ones
`timescale 1ns/1ns
`default_nettype none
module hms_host_model (
  input wire logic clk, // Core clock
  input wire logic resetCycleBusy, // Device reset cycle
  output logic regWrEn, // Write strobe
  output logic regRdEn, // Read strobe
  output logic [15:0] regAddr, // Word address
  output logic [15:0] regWrData, // Write data
  input wire logic [15:0] regRdData, // Read data
  input wire logic regRdValid // Read answer
);
  // Quiet bus at start
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 16'h5a5a;
    regWrData = 16'ha5a5;
  end

  // Hold off transfers until the post-reset wait is over
  task automatic settle();
    int n;
    n = 0;
    while (resetCycleBusy !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    settle();
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  // Answer lands on the edge after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    settle();
    @(negedge clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
    v = regRdValid;
  endtask
endmodule
`default_nettype wire

// ---- hms_mode_select_tb.sv ----
// Purpose: Self-checking bench for the mode-select block
// Assumes: RST_CYCLES shortened to 4; pixel values give exact angles
// Notes: Magnitude and angle allow a few LSB of CORDIC error
`timescale 1ns/1ns
`default_nettype none
module hms_mode_select_tb;
  logic clk, rst, lowPowerPin, regWrEn, regRdEn, measTrigger, sampleValid;
  logic [15:0] regAddr, regWrData, regRdData, rdat;
  logic regRdValid, analogEnable, measBusy, resultValid, rval;
  logic readyPinTristate, magnetRangeExtension, resetCycleBusy;
  logic signed [15:0] px [6];
  int nErrors, checksDone, cycles, n;
  // Pixel values x0, y0, z0, x1, y1, z1
  logic [15:0] pv [6] = '{16'h0064, 16'hff38, 16'h012c, 16'h044c, 16'h0708, 16'h0514};
  logic [15:0] setv [3] = '{16'h0892, 16'h00c2, 16'h08d2};
  logic [15:0] addrs [7] = '{16'h0111, 16'h0112, 16'h0113, 16'h0114, 16'h0120, 16'h0121, 16'h0122};
  logic [15:0] expv [3][7] = '{
    '{16'h012c, 16'h0514, 16'h0064, 16'h044c, 16'h048c, 16'h2000, 16'h2000},
    '{16'hff38, 16'h0708, 16'h0064, 16'h044c, 16'h00b8, 16'hd2e4, 16'hd2e4},
    '{16'hff38, 16'h0708, 16'h0064, 16'h044c, 16'h0731, 16'h2d1c, 16'h2d1c}};

  hms_mode_select #(.RST_CYCLES(4)) u_hms_mode_select (
    .clk(clk), .rst(rst), .lowPowerPin(lowPowerPin), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .measTrigger(measTrigger), .sampleValid(sampleValid), .pixBx0(px[0]), .pixBy0(px[1]),
    .pixBz0(px[2]), .pixBx1(px[3]), .pixBy1(px[4]), .pixBz1(px[5]),
    .analogEnable(analogEnable), .measBusy(measBusy), .resultValid(resultValid),
    .readyPinTristate(readyPinTristate), .magnetRangeExtension(magnetRangeExtension),
    .resetCycleBusy(resetCycleBusy));

  hms_host_model u_hms_host_model (
    .clk(clk), .resetCycleBusy(resetCycleBusy), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    if (nErrors == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Unknown bits never fall inside the tolerance
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    logic signed [17:0] d;
    d = $signed({2'b00, got}) - $signed({2'b00, exp});
    checksDone++;
    if (!((d <= $signed({2'b00, tol}) && d >= -$signed({2'b00, tol})) === 1'b1)) begin
      nErrors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [15:0] e, input logic v,
                       input logic [15:0] tol);
    u_hms_host_model.rd(a, rdat, rval);
    chk({15'h0000, rval}, {15'h0000, v}, 16'h0000);
    chk(rdat, e, tol);
  endtask

  // Trigger, optional settings write mid-cycle, one sample, wait for results
  task automatic measure(input logic [15:0] midSet);
    @(negedge clk);
    measTrigger = 1'b1;
    @(negedge clk);
    measTrigger = 1'b0;
    if (midSet !== 16'h0000) u_hms_host_model.wr(16'h000b, midSet);
    @(negedge clk);
    foreach (px[i]) px[i] = pv[i];
    sampleValid = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    foreach (px[i]) px[i] = ~pv[i];
    n = 0;
    while (resultValid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, resultValid}, 16'h0001, 16'h0000);
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      nErrors++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    lowPowerPin = 1'b0;
    measTrigger = 1'b0;
    sampleValid = 1'b0;
    foreach (px[i]) px[i] = ~pv[i];
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rdChk(16'h000b, 16'h0002, 1'b1, 16'h0000);
    u_hms_host_model.wr(16'h000b, 16'hffff);
    rdChk(16'h000b, 16'h08d2, 1'b1, 16'h0000);
    chk({15'h0000, magnetRangeExtension}, 16'h0001, 16'h0000);
    rdChk(16'h0000, 16'h0000, 1'b1, 16'h0000);
    u_hms_host_model.wr(16'h0120, 16'h1234);
    rdChk(16'h0120, 16'h0000, 1'b1, 16'h0000);
    // Undefined mode code: ready bit cleared, trigger must be ignored
    u_hms_host_model.wr(16'h000b, 16'h0800);
    chk({15'h0000, readyPinTristate}, 16'h0000, 16'h0000);
    @(negedge clk);
    measTrigger = 1'b1;
    @(negedge clk);
    measTrigger = 1'b0;
    chk({15'h0000, measBusy}, 16'h0000, 16'h0000);
    // Each mode in turn; the last run rewrites the mode while acquiring
    for (int m = 0; m < 3; m++) begin
      u_hms_host_model.wr(16'h000b, setv[m]);
      rdChk(16'h000b, setv[m], 1'b1, 16'h0000);
      measure((m == 2) ? 16'h0892 : 16'h0000);
      for (int r = 0; r < 7; r++) begin
        rdChk(addrs[r], expv[m][r], 1'b1, (r > 3) ? 16'h0004 : 16'h0000);
      end
    end
    // Low power in mid-measurement, then the reset cycle on leaving it
    @(negedge clk);
    measTrigger = 1'b1;
    @(negedge clk);
    measTrigger = 1'b0;
    lowPowerPin = 1'b1;
    repeat (8) @(negedge clk);
    chk({15'h0000, analogEnable}, 16'h0000, 16'h0000);
    chk({15'h0000, measBusy}, 16'h0000, 16'h0000);
    rdChk(16'h000b, 16'h0000, 1'b0, 16'h0000);
    lowPowerPin = 1'b0;
    n = 0;
    while (resetCycleBusy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, resetCycleBusy}, 16'h0001, 16'h0000);
    rdChk(16'h000b, 16'h0002, 1'b1, 16'h0000);
    rdChk(16'h0111, 16'h0000, 1'b1, 16'h0000);
    u_hms_host_model.wr(16'h000b, 16'h0892);
    rdChk(16'h000b, 16'h0892, 1'b1, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
